// ### rtl/pscfg_decode.sv
`timescale 1ns/1ps
`include "pscfg_map.svh"
// pure decode of the four mode straps into a configuration set
module pscfg_decode
(
    // strap code
    input  wire logic [3:0]                 i_code,
    // decoded configuration
    output pscfg_pkg::pscfg_power_t         o_power,
    output logic [10:0]                     o_decim,
    output logic [2:0]                      o_gain_hi,
    output logic                            o_int_ref
);
    import pscfg_pkg::*;

    // ==========================================================
    // mode table
    always_comb
    begin
        o_power   = PSCFG_HIGH_RES;
        o_gain_hi = 3'h1;
        o_int_ref = 1'b0;
        case (i_code)
            4'h0: o_decim = 11'h400;
            4'h1: o_decim = 11'h200;
            4'h2: o_decim = 11'h100;
            4'h3: o_decim = 11'h080;
            4'h4: o_decim = 11'h100;
            4'h5: o_decim = 11'h200;
            4'h6: o_decim = 11'h100;
            4'h7: o_decim = 11'h080;
            4'h8: o_decim = 11'h200;
            4'h9: o_decim = 11'h100;
            4'hA: o_decim = 11'h080;
            4'hB: o_decim = 11'h200;
            4'hC: o_decim = 11'h100;
            4'hD: o_decim = 11'h080;
            4'hE: o_decim = 11'h080;
            default: o_decim = 11'h100;
        endcase
        if (i_code >= 4'hB)
            o_power = PSCFG_LOW_POWER;
        // upper channel group gain; lower group is fixed at 1
        if (i_code == 4'h4)
            o_gain_hi = 3'h2;
        else if (i_code >= 4'h5 && i_code <= 4'h7)
            o_gain_hi = 3'h4;
        // internal reference codes
        if (i_code inside {4'h8, 4'h9, 4'hA, 4'hE, 4'hF})
            o_int_ref = 1'b1;
    end
endmodule

// ### rtl/pscfg_map.svh
`ifndef PSCFG_MAP_SVH
`define PSCFG_MAP_SVH
// What this block does
// - start input resynchronised, drives sync pulse out
// - toggling user_config_two bit 0 emits sync pulse in serial control
// - main notch at the mode's max rate
// - pin mode config from four mode straps
// - strap code selects power mode and decimation
// - gain 1 low group, 2/4 upper group by code
// - internal reference for codes 8,9,A,E,F
// - rate is 2048 or 512 kHz over decimation
// - format straps pick lane layout or serial control
// - output-select high gives SPI readout or control
// - bit clock divider is two to strap code
// - straps re-sampled on every sync in pulse
// - pin mode disables rate converter and diagnostics
// - sync in resets digital block, keeps registers
// - modulator clock divides by 4 or 8

// ==========================================================
// register offsets (byte addresses)
`define PSCFG_OFS_USER_CONFIG_TWO 12'h014
`define PSCFG_OFS_OUTPUT_MODE     12'h018
`define PSCFG_OFS_STATUS          12'h01C
`define PSCFG_OFS_RATE            12'h020
// ==========================================================
// field positions
`define PSCFG_SYNC_TOGGLE_BIT     0
// ==========================================================
// reset values
`define PSCFG_USER_CFG_RST        8'h00
`define PSCFG_OUT_MODE_RST        2'h0
// ==========================================================
// rates and divisors
`define PSCFG_MAX_RATE_HR_HZ      16000
`define PSCFG_MAX_RATE_LP_HZ      8000
`define PSCFG_RATE_NUM_HR         2048
`define PSCFG_RATE_NUM_LP         512
`define PSCFG_MOD_DIV_HR          4
`define PSCFG_MOD_DIV_LP          8
// ==========================================================
// boot load timing (edges after reset release, minus one)
`define PSCFG_BOOT_LOAD_CNT       3'h4
`define PSCFG_BOOT_DONE_CNT       3'h5
`endif

// ### rtl/pscfg_pkg.sv
package pscfg_pkg;
    // power mode
    typedef enum logic { PSCFG_HIGH_RES, PSCFG_LOW_POWER } pscfg_power_t;
    // control mode
    typedef enum logic { PSCFG_PIN_CTRL, PSCFG_SPI_CTRL } pscfg_ctrl_t;
    // output lane layout
    typedef enum logic [2:0]
    {
        PSCFG_FOUR_LANES,
        PSCFG_TWO_LANES,
        PSCFG_ONE_LANE,
        PSCFG_SPI_READOUT,
        PSCFG_REG_DEFINED
    } pscfg_layout_t;
endpackage

// ### rtl/pscfg_sync3.sv
`timescale 1ns/1ps
// three-stage input synchroniser; output changes when stages 2 and 3 agree
module pscfg_sync3
(
    // clocking
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    // data
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_reg;   // metastable stage, read only by s2
    logic s2_reg;
    logic s3_reg;

    // ==========================================================
    // shift chain
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ==========================================================
    // agreed level, held until the two late stages agree again
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_level <= 1'b0;
        else if (i_ce && (s2_reg == s3_reg))
            o_level <= s3_reg;
    end
endmodule

// ### rtl/pscfg_top.sv
`timescale 1ns/1ps
`include "pscfg_map.svh"
// strap configuration loader with sync pulse generation
module pscfg_top
(
    // clocking
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_resetn,
    input  wire logic                       i_ce,
    // apb slave
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [11:0]                i_paddr,
    input  wire logic [31:0]                i_pwdata,
    output logic [31:0]                     o_prdata,
    output logic                            o_pready,
    output logic                            o_pslverr,
    // sync pins
    input  wire logic                       i_start_n,
    input  wire logic                       i_sync_in,
    output logic                            o_sync_out,
    // straps
    input  wire logic                       i_strap_bit_zero,
    input  wire logic                       i_strap_bit_one,
    input  wire logic                       i_strap_bit_two,
    input  wire logic                       i_strap_bit_three,
    input  wire logic                       i_format_strap_low,
    input  wire logic                       i_format_strap_high,
    input  wire logic                       i_output_select_strap,
    input  wire logic                       i_divider_strap_zero,
    input  wire logic                       i_divider_strap_one,
    input  wire logic                       i_divider_strap_two,
    // decoded configuration
    output pscfg_pkg::pscfg_power_t         o_power_mode,
    output logic [10:0]                     o_decimation,
    output logic [2:0]                      o_gain_lo,
    output logic [2:0]                      o_gain_hi,
    output logic                            o_int_ref,
    output pscfg_pkg::pscfg_ctrl_t          o_ctrl_mode,
    output pscfg_pkg::pscfg_layout_t        o_lane_layout,
    output logic [7:0]                      o_bitclk_div,
    output logic [3:0]                      o_mod_div,
    output logic [15:0]                     o_output_rate_hz,
    output logic [15:0]                     o_main_notch_hz,
    output logic                            o_rate_conv_en,
    output logic                            o_diag_en,
    output logic                            o_digital_reset
);
    import pscfg_pkg::*;

    // ==========================================================
    // synchronised pins
    logic       start_lvl;      // start pin level; reset value matches its tied-low idle
    logic       syncin_lvl;     // sync input level
    logic [9:0] strap_lvl;      // all straps, synchronised
    logic [9:0] strap_raw;      // straps as pins

    assign strap_raw = {i_divider_strap_two, i_divider_strap_one,
                        i_divider_strap_zero, i_output_select_strap,
                        i_format_strap_high, i_format_strap_low,
                        i_strap_bit_three, i_strap_bit_two,
                        i_strap_bit_one, i_strap_bit_zero};

    pscfg_sync3 u_sync_start
    (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_async   (i_start_n),
        .o_level   (start_lvl)
    );

    pscfg_sync3 u_sync_in
    (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_async   (i_sync_in),
        .o_level   (syncin_lvl)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_strap
            pscfg_sync3 u_s
            (
                .i_sys_clk (i_sys_clk),
                .i_resetn  (i_resetn),
                .i_ce      (i_ce),
                .i_async   (strap_raw[gi]),
                .o_level   (strap_lvl[gi])
            );
        end
    endgenerate

    // ==========================================================
    // edge detection on agreed levels
    logic start_d_reg;
    logic syncin_d_reg;
    logic start_rise;
    logic syncin_rise;

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            start_d_reg  <= 1'b0;
            syncin_d_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            start_d_reg  <= start_lvl;
            syncin_d_reg <= syncin_lvl;
        end
    end

    assign start_rise  = start_d_reg & ~start_lvl;      // pin fell: start asserted
    assign syncin_rise = syncin_lvl & ~syncin_d_reg;

    // ==========================================================
    // apb registers
    logic [7:0] user_config_two_reg;    // bit 0 toggles a sync pulse
    logic [1:0] out_mode_reg;           // output mode for register-defined layout
    logic       toggle_hit;             // write changed bit 0
    logic       apb_wr;
    logic       apb_rd;
    logic       load_pend_reg;          // straps still to be sampled after reset

    assign apb_wr = i_psel & i_penable & i_pwrite;
    assign apb_rd = i_psel & i_penable & ~i_pwrite;
    assign toggle_hit = apb_wr && (i_paddr == `PSCFG_OFS_USER_CONFIG_TWO)
        && (i_pwdata[`PSCFG_SYNC_TOGGLE_BIT]
            != user_config_two_reg[`PSCFG_SYNC_TOGGLE_BIT]);

    // register writes; a sync in pulse leaves these untouched
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            user_config_two_reg <= `PSCFG_USER_CFG_RST;
            out_mode_reg        <= `PSCFG_OUT_MODE_RST;
        end
        else if (i_ce && apb_wr)
        begin
            if (i_paddr == `PSCFG_OFS_USER_CONFIG_TWO)
                user_config_two_reg <= i_pwdata[7:0];
            else if (i_paddr == `PSCFG_OFS_OUTPUT_MODE)
                out_mode_reg <= i_pwdata[1:0];
        end
    end

    // zero-wait answer, registered read data
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else if (i_ce)
        begin
            // ready is raised in the first access cycle and dropped after
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable)
            begin
                case (i_paddr)
                    `PSCFG_OFS_USER_CONFIG_TWO: o_prdata <= {24'h0, user_config_two_reg};
                    `PSCFG_OFS_OUTPUT_MODE:     o_prdata <= {30'h0, out_mode_reg};
                    `PSCFG_OFS_STATUS:          o_prdata <= {12'h0, o_int_ref,
                        o_gain_hi, o_decimation, o_power_mode, o_ctrl_mode,
                        o_lane_layout};
                    `PSCFG_OFS_RATE:            o_prdata <= {o_main_notch_hz,
                        o_output_rate_hz};
                    default:
                    begin
                        o_prdata  <= 32'h0000_0000;
                        o_pslverr <= 1'b1;      // unmapped address
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // sync pulse output: one cycle per start edge or serial-control register toggle
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_sync_out <= 1'b0;
        else if (i_ce)
        begin
            // toggle only counts in serial control mode
            o_sync_out <= start_rise
                | (toggle_hit && o_ctrl_mode == PSCFG_SPI_CTRL);
        end
    end

    // ==========================================================
    // strap sampling: once after reset release, then on each sync in
    logic       sample_now;
    assign sample_now = load_pend_reg | syncin_rise;

    // agreed levels appear at the fourth edge, so the first load waits for the sixth
    logic [2:0] boot_cnt_reg;
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            boot_cnt_reg  <= 3'h0;
            load_pend_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            load_pend_reg <= (boot_cnt_reg == `PSCFG_BOOT_LOAD_CNT);
            if (boot_cnt_reg != `PSCFG_BOOT_DONE_CNT)
                boot_cnt_reg <= boot_cnt_reg + 3'h1;
        end
    end

    // digital block reset pulse, one cycle per sync in edge
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_digital_reset <= 1'b0;
        else if (i_ce)
            o_digital_reset <= syncin_rise;
    end

    // ==========================================================
    // decode of the mode straps
    pscfg_power_t dec_power;
    logic [10:0]  dec_decim;
    logic [2:0]   dec_gain_hi;
    logic         dec_int_ref;

    pscfg_decode u_decode
    (
        .i_code    (strap_lvl[3:0]),
        .o_power   (dec_power),
        .o_decim   (dec_decim),
        .o_gain_hi (dec_gain_hi),
        .o_int_ref (dec_int_ref)
    );

    // control mode and layout from format and output-select straps
    pscfg_ctrl_t   ctrl_next;
    pscfg_layout_t layout_next;
    always_comb
    begin
        ctrl_next   = PSCFG_PIN_CTRL;
        layout_next = PSCFG_FOUR_LANES;
        case ({strap_lvl[6], strap_lvl[5], strap_lvl[4]})
            3'b000: layout_next = PSCFG_FOUR_LANES;
            3'b001: layout_next = PSCFG_TWO_LANES;
            3'b010: layout_next = PSCFG_ONE_LANE;
            3'b100, 3'b101, 3'b110:
                layout_next = PSCFG_SPI_READOUT;
            default:
            begin
                ctrl_next   = PSCFG_SPI_CTRL;
                layout_next = PSCFG_REG_DEFINED;
            end
        endcase
    end

    // latch the configuration at each sampling moment
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_power_mode  <= PSCFG_HIGH_RES;
            o_decimation  <= 11'h400;
            o_gain_lo     <= 3'h1;
            o_gain_hi     <= 3'h1;
            o_int_ref     <= 1'b0;
            o_ctrl_mode   <= PSCFG_PIN_CTRL;
            o_lane_layout <= PSCFG_FOUR_LANES;
            o_bitclk_div  <= 8'h01;
        end
        else if (i_ce && sample_now)
        begin
            o_power_mode  <= dec_power;
            o_decimation  <= dec_decim;
            o_gain_lo     <= 3'h1;
            o_gain_hi     <= dec_gain_hi;
            o_int_ref     <= dec_int_ref;
            o_ctrl_mode   <= ctrl_next;
            o_lane_layout <= layout_next;
            o_bitclk_div  <= 8'h01 << strap_lvl[9:7];
        end
    end

    // ==========================================================
    // derived rates; divider is slow but only follows a strap load
    logic [15:0] rate_num;
    assign rate_num = (o_power_mode == PSCFG_HIGH_RES) ? 16'(`PSCFG_RATE_NUM_HR)
                                                       : 16'(`PSCFG_RATE_NUM_LP);

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_output_rate_hz <= 16'h0000;
            o_main_notch_hz  <= 16'h0000;
            o_mod_div        <= 4'h4;
            o_rate_conv_en   <= 1'b0;
            o_diag_en        <= 1'b0;
        end
        else if (i_ce)
        begin
            // rate in hz: 1000 * num / decimation, always exact here
            o_output_rate_hz <= 16'((32'(rate_num) * 32'd1000)
                                    / 32'(o_decimation));
            // notch placed at the maximum rate of the mode
            o_main_notch_hz  <= (o_power_mode == PSCFG_HIGH_RES)
                ? 16'(`PSCFG_MAX_RATE_HR_HZ) : 16'(`PSCFG_MAX_RATE_LP_HZ);
            o_mod_div        <= (o_power_mode == PSCFG_HIGH_RES)
                ? 4'(`PSCFG_MOD_DIV_HR) : 4'(`PSCFG_MOD_DIV_LP);
            o_rate_conv_en   <= (o_ctrl_mode == PSCFG_SPI_CTRL);
            o_diag_en        <= (o_ctrl_mode == PSCFG_SPI_CTRL);
        end
    end
endmodule

// ### testbench/pscfg_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host side: start pin and sync loopback on the shared clock
module pscfg_host_model
(
    // clocking
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    // bench request and device pins
    input  wire logic i_start_req,
    input  wire logic i_sync_out,
    output logic      o_start_n,
    output logic      o_sync_in
);
    logic [2:0] start_cnt_reg;  // start pin pulse timer
    logic [2:0] loop_cnt_reg;   // loopback stretch timer
    // start idles low when unused; a request lifts it and its fall fires
    always_ff @(posedge i_sys_clk or negedge i_resetn)
        if (!i_resetn)
            start_cnt_reg <= 3'h0;
        else if (i_start_req)
            start_cnt_reg <= 3'h5;
        else if (start_cnt_reg != 3'h0)
            start_cnt_reg <= start_cnt_reg - 3'h1;
    assign o_start_n = (start_cnt_reg > 3'h1);
    // widened so the input synchroniser sees equal samples
    always_ff @(posedge i_sys_clk or negedge i_resetn)
        if (!i_resetn)
            loop_cnt_reg <= 3'h0;
        else if (i_sync_out)
            loop_cnt_reg <= 3'h4;
        else if (loop_cnt_reg != 3'h0)
            loop_cnt_reg <= loop_cnt_reg - 3'h1;
    assign o_sync_in = (loop_cnt_reg != 3'h0);
endmodule

// ### testbench/pscfg_top_asserts.sv
`timescale 1ns/1ps
// ==========================================
// port-level checks of the strap loader
module pscfg_top_asserts
(
    // clocking
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_resetn,
    // apb handshake
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 o_pready,
    input  wire logic                 o_pslverr,
    // pulses
    input  wire logic                 o_sync_out,
    input  wire logic                 o_digital_reset,
    // decoded configuration
    input  wire pscfg_pkg::pscfg_power_t  o_power_mode,
    input  wire logic [10:0]          o_decimation,
    input  wire logic [2:0]           o_gain_lo,
    input  wire pscfg_pkg::pscfg_ctrl_t   o_ctrl_mode,
    input  wire pscfg_pkg::pscfg_layout_t o_lane_layout,
    input  wire logic [7:0]           o_bitclk_div,
    input  wire logic [3:0]           o_mod_div,
    input  wire logic [15:0]          o_output_rate_hz,
    input  wire logic [15:0]          o_main_notch_hz,
    input  wire logic                 o_rate_conv_en,
    input  wire logic                 o_diag_en
);
    import pscfg_pkg::*;
    logic [3:0] age_reg;  // cycles since reset, saturating
    // rates read 0 only until the first edge after reset, then follow each strap load a cycle late, so wait before judging them
    always_ff @(posedge i_sys_clk or negedge i_resetn)
        if (!i_resetn)
            age_reg <= 4'h0;
        else if (age_reg != 4'hF)
            age_reg <= age_reg + 4'h1;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sync_pulse_a: assert property (o_sync_out |=> !o_sync_out)
        else $error("sync out longer than one cycle");
    reset_pulse_a: assert property (o_digital_reset |=> !o_digital_reset)
        else $error("digital reset longer than one cycle");
    low_gain_a: assert property (o_gain_lo == 3'h1)
        else $error("lower channel gain not 1");
    mod_div_a: assert property (!$changed(o_power_mode) |->
        o_mod_div == ((o_power_mode == PSCFG_LOW_POWER) ? 4'h8 : 4'h4))
        else $error("modulator divider wrong");
    pin_feat_a: assert property (o_ctrl_mode == PSCFG_PIN_CTRL && $stable(o_ctrl_mode)
        |-> !o_rate_conv_en && !o_diag_en) else $error("feature on in pin mode");
    rate_calc_a: assert property (age_reg == 4'hF && o_ctrl_mode == PSCFG_PIN_CTRL
        && $stable(o_decimation) && $stable(o_power_mode) |-> o_output_rate_hz ==
        16'(((o_power_mode == PSCFG_LOW_POWER) ? 32'h7D000 : 32'h1F4000) / o_decimation))
        else $error("output rate wrong");
    notch_a: assert property (age_reg == 4'hF && $stable(o_power_mode) |->
        o_main_notch_hz == ((o_power_mode == PSCFG_LOW_POWER) ? 16'h1F40 : 16'h3E80))
        else $error("main notch wrong");
    div_pow_a: assert property (o_bitclk_div != 8'h00 &&
        (o_bitclk_div & (o_bitclk_div - 8'h01)) == 8'h00) else $error("divider not 2^n");
    ctrl_layout_a: assert property ((o_ctrl_mode == PSCFG_SPI_CTRL) ==
        (o_lane_layout == PSCFG_REG_DEFINED)) else $error("control and layout disagree");
    apb_ready_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    err_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    cover property (o_sync_out);
    cover property (o_digital_reset);
    cover property (o_pslverr);
    cover property (o_diag_en);
endmodule

bind pscfg_top pscfg_top_asserts u_chk (.i_sys_clk, .i_resetn, .i_psel, .i_penable,
    .o_pready, .o_pslverr, .o_sync_out, .o_digital_reset, .o_power_mode, .o_decimation,
    .o_gain_lo, .o_ctrl_mode, .o_lane_layout, .o_bitclk_div, .o_mod_div,
    .o_output_rate_hz, .o_main_notch_hz, .o_rate_conv_en, .o_diag_en);

// ### testbench/pscfg_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
// ==========================================
// bench: strap sweeps, sync paths, apb access
module pscfg_top_tb;
    import pscfg_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, start_req = 1'b0, osel = 1'b0, e;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic start_n, sync_in, sync_out, int_ref, rc_en, diag_en, dig_rst, lp;
    logic [3:0] mode = 4'h1, mdiv;
    logic [1:0] fmt = 2'h0;
    logic [2:0] div = 3'h0, glo, ghi;
    logic [7:0] bdiv, exp_bdiv = 8'h01;
    logic [10:0] decim;
    logic [15:0] rate, notch;
    pscfg_power_t power;
    pscfg_ctrl_t ctrl;
    pscfg_layout_t layout;
    int n_fail = 0, tests_run = 0, n_sync = 0, n0;
    logic [10:0] dec_t [16] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h100, 11'h200,
        11'h100, 11'h080, 11'h200, 11'h100, 11'h080, 11'h200, 11'h100, 11'h080, 11'h080,
        11'h100};
    always #2 sys_clk = ~sys_clk;
    // counts every sync out pulse
    always @(posedge sys_clk) if (sync_out === 1'b1) n_sync <= n_sync + 1;
    pscfg_top dut (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_ce(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_start_n(start_n),
        .i_sync_in(sync_in), .o_sync_out(sync_out), .i_strap_bit_zero(mode[0]),
        .i_strap_bit_one(mode[1]), .i_strap_bit_two(mode[2]), .i_strap_bit_three(mode[3]),
        .i_format_strap_low(fmt[0]), .i_format_strap_high(fmt[1]),
        .i_output_select_strap(osel), .i_divider_strap_zero(div[0]),
        .i_divider_strap_one(div[1]), .i_divider_strap_two(div[2]), .o_power_mode(power),
        .o_decimation(decim), .o_gain_lo(glo), .o_gain_hi(ghi), .o_int_ref(int_ref),
        .o_ctrl_mode(ctrl), .o_lane_layout(layout), .o_bitclk_div(bdiv), .o_mod_div(mdiv),
        .o_output_rate_hz(rate), .o_main_notch_hz(notch), .o_rate_conv_en(rc_en),
        .o_diag_en(diag_en), .o_digital_reset(dig_rst));
    pscfg_host_model host (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_start_req(start_req),
        .i_sync_out(sync_out), .o_start_n(start_n), .o_sync_in(sync_in));
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // new straps, start pulse, wait for the reload
    task automatic do_sync(input logic [3:0] m, input logic [1:0] f, input logic o,
                           input logic [2:0] dv);
        mode <= m; fmt <= f; osel <= o; div <= dv;
        repeat (8) @(posedge sys_clk);
        `CHK(bdiv, exp_bdiv)
        n0 = n_sync;
        start_req <= 1'b1;
        @(posedge sys_clk);
        start_req <= 1'b0;
        do @(posedge sys_clk); while (dig_rst !== 1'b1);
        repeat (3) @(posedge sys_clk);
        `CHK(n_sync - n0, 1)
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #50000;
        n_fail++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (12) @(posedge sys_clk);
        `CHK(decim, 11'h200)
        `CHK(n_sync, 0)
        // sweep every mode code, divider code and pin-mode layout
        for (int i = 0; i < 16; i++)
        begin
            do_sync(i[3:0], 2'(i % 3), i[3], i[2:0]);
            lp = (i >= 11);
            `CHK(power, lp ? PSCFG_LOW_POWER : PSCFG_HIGH_RES)
            `CHK(decim, dec_t[i])
            `CHK(glo, 3'h1)
            `CHK(ghi, (i == 4) ? 3'h2 : (i inside {[5:7]}) ? 3'h4 : 3'h1)
            `CHK(int_ref, 1'(i inside {8, 9, 10, 14, 15}))
            `CHK(rate, 16'((lp ? 32'h7D000 : 32'h1F4000) / dec_t[i]))
            `CHK(notch, lp ? 16'h1F40 : 16'h3E80)
            `CHK(mdiv, lp ? 4'h8 : 4'h4)
            `CHK(bdiv, 8'h01 << i[2:0])
            `CHK(layout, i[3] ? PSCFG_SPI_READOUT : pscfg_layout_t'(i % 3))
            `CHK({ctrl, rc_en, diag_en}, 3'h0)
            exp_bdiv = 8'h01 << i[2:0];
        end
        // serial control: register toggles emit sync pulses
        do_sync(4'h0, 2'h3, 1'b0, 3'h0);
        exp_bdiv = 8'h01;
        `CHK({ctrl, layout}, {PSCFG_SPI_CTRL, PSCFG_REG_DEFINED})
        `CHK(diag_en, 1'b1)
        n0 = n_sync;
        for (int t = 0; t < 3; t++)
            apb(1'b1, 12'h014, 32'(t == 0));
        repeat (10) @(posedge sys_clk);
        `CHK(n_sync - n0, 2)
        apb(1'b0, 12'h01C, 32'h0);
        `CHK({e, q}, 33'h00001800C)
        apb(1'b1, 12'hFF0, 32'hFFFFFFFF);
        `CHK(e, 1'b1)
        apb(1'b0, 12'hFF0, 32'h0);
        `CHK({e, q}, 33'h100000000)
        // back to pin control: toggle is refused but still stored
        do_sync(4'h0, 2'h0, 1'b0, 3'h0);
        n0 = n_sync;
        apb(1'b1, 12'h014, 32'h1);
        repeat (10) @(posedge sys_clk);
        `CHK(n_sync - n0, 0)
        apb(1'b0, 12'h014, 32'h0);
        `CHK({e, q[7:0]}, 9'h001)
        stop_test();
    end
endmodule
